/* core/e1s_pkg.sv */
// package: register map, status bit layout and timing counts for the E1 status block
// How it works
// RULE1: receive alarm mask bit 0 masks, 1 enables the matching alarm flag.
// RULE2: timing event mask bit 0 masks, 1 enables same-position status bit.
// RULE3: receive signaling multiframe flag, bit 7, sets on every receive multiframe.
// RULE4: receive align frame flag, bit 6, sets at each receive align frame.
// RULE5: transmit multiframe flag, bit 5, sets on every transmit multiframe.
// RULE6: interval timer flag, bit 4, each second of receive clock, or 62.5ms.
// RULE7: transmit align frame flag, bit 3, sets at each transmit align frame.
// RULE8: transmit clock loss flag, bit 2, after 3.9ms without transitions.
// RULE9: CRC4 multiframe flag, bit 1; free 2ms boundary when CRC4 is off.
// RULE10: pattern detect flag, bit 0, sets when 2^15-1 sequence is locked.
// RULE11: all four error counters latch together at each interval boundary.
// RULE12: every error counter saturates at its maximum, never wraps.
// RULE13: in pattern mode the far-end counter counts pattern bit errors.
// RULE14: violation count is 16 bits, high byte 00, low byte 01; bipolar mode.
// RULE15: in HDB3 mode substitution codewords are not counted as violations.
// RULE16: count select 1 counts code violations: same-polarity violation pairs.
// RULE17: violation counting never stops for sync loss; saturates at 65535.
// RULE18: host should pick bipolar mode for AMI lines, code mode for HDB3.
// RULE19: CRC4 error count is 16 bits, high byte 02, low byte 03.
// RULE20: CRC4 counting halts on frame or CRC4 multiframe sync loss only.
// RULE21: host must read counters within one interval after the timer flag.
// RULE22: receive alarm mask bits line up with the alarm status at 0A.
// RULE23: interrupt asserts while any status bit is set with its mask bit 1.
// RULE24: at each boundary running counts move to readable registers and clear.
package e1s_pkg;
	localparam logic [7:0] ADDR_VIOL_HI   = 8'h00;
	localparam logic [7:0] ADDR_VIOL_LO   = 8'h01;
	localparam logic [7:0] ADDR_CRC_HI    = 8'h02;
	localparam logic [7:0] ADDR_CRC_LO    = 8'h03;
	localparam logic [7:0] ADDR_FEBE_HI   = 8'h04;
	localparam logic [7:0] ADDR_FEBE_LO   = 8'h05;
	localparam logic [7:0] ADDR_FAS_HI    = 8'h06;
	localparam logic [7:0] ADDR_FAS_LO    = 8'h07;
	localparam logic [7:0] ADDR_ALARM_ST  = 8'h0a;
	localparam logic [7:0] ADDR_EVENT_ST  = 8'h0b;
	localparam logic [7:0] ADDR_ALARM_MSK = 8'h18;
	localparam logic [7:0] ADDR_EVENT_MSK = 8'h19;
	// timing event status bit positions
	localparam int BIT_RX_MF    = 7;
	localparam int BIT_RX_ALIGN = 6;
	localparam int BIT_TX_MF    = 5;
	localparam int BIT_TIMER    = 4;
	localparam int BIT_TX_ALIGN = 3;
	localparam int BIT_TX_CLKLOSS = 2;
	localparam int BIT_CRC_MF   = 1;
	localparam int BIT_PATTERN  = 0;
	localparam logic [7:0] REG_RESET = 8'h00;
	// timing, counted in receive bits at 2048 kbit/s or in clk cycles
	localparam int RX_BIT_RATE_HZ   = 2048000;
	localparam int ONE_SEC_BITS     = RX_BIT_RATE_HZ;
	localparam int FAST_INTERVAL_US = 62500;
	localparam int FAST_BITS        = RX_BIT_RATE_HZ / 1000 * FAST_INTERVAL_US / 1000;
	localparam int CRC_FREE_MS      = 2;
	localparam int CRC_FREE_BITS    = RX_BIT_RATE_HZ / 1000 * CRC_FREE_MS;
	localparam int CLK_PERIOD_NS    = 8;
	localparam int TX_LOSS_NS       = 3900000;
	localparam int TX_LOSS_CYCLES   = (TX_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PATTERN_LOCK_BITS = 32;
	localparam int PATTERN_DROP_ERRS = 8;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
endpackage : e1s_pkg

/* core/e1s_status_counters.sv */
// module: status flags, interrupt masks and interval error counters of one E1 framer
`timescale 1ns/10ps
`default_nettype none
module e1s_status_counters #(
	parameter int ONE_SEC_BITS   = e1s_pkg::ONE_SEC_BITS,
	parameter int FAST_BITS      = e1s_pkg::FAST_BITS,
	parameter int TX_LOSS_CYCLES = e1s_pkg::TX_LOSS_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [7:0] hostAddr,
	input  wire logic       hostWrite,
	input  wire logic       hostRead,
	input  wire logic [7:0] hostWriteData,
	output var  logic [7:0] hostReadData,
	output var  logic       interruptReq,
	input  wire logic       rxBitStrobe,
	input  wire logic       rxPositiveRail,
	input  wire logic       rxNegativeRail,
	input  wire logic       rxDataBit,
	input  wire logic [7:0] rxAlarmLevels,
	input  wire logic       rxSignalingMfStart,
	input  wire logic       rxAlignFrameStart,
	input  wire logic       txMultiframeStart,
	input  wire logic       txAlignFrameStart,
	input  wire logic       rxCrcMfStart,
	input  wire logic       crc4Enable,
	input  wire logic       crcWordError,
	input  wire logic       frameSyncLost,
	input  wire logic       crcMfSyncLost,
	input  wire logic       farEndBlockError,
	input  wire logic       fasWordError,
	input  wire logic       receiveSyncLoss,
	input  wire logic       transmitLineClock,
	input  wire logic       prbsEnable,
	input  wire logic       fastIntervalSelect,
	input  wire logic       violationCountSelect,
	input  wire logic       rxHdb3Enable
);
	// saturating add of one event to a running count
	function automatic logic [15:0] satInc(input logic [15:0] v, input logic ev);
		satInc = (ev && v != e1s_pkg::COUNT_MAX) ? v + 16'h0001 : v;
	endfunction : satInc

	// running count after a boundary restarts it with this cycle's event
	function automatic logic [15:0] nextRun(input logic [15:0] v, input logic ev,
			input logic bnd);
		nextRun = bnd ? {15'h0000, ev} : satInc(v, ev);
	endfunction : nextRun

	logic [7:0]  alarmMask;
	logic [7:0]  eventMask;
	logic [7:0]  alarmStatus;
	logic [7:0]  eventStatus;
	logic [7:0]  eventSet;
	logic [20:0] intervalCount;
	logic        intervalEnd;
	logic [12:0] crcFreeCount;
	logic        crcFreeEnd;
	logic        txClkMeta;
	logic        txClkSync;
	logic        txClkLast;
	logic [18:0] txIdleCount;
	logic        txClkLost;
	logic        lastMarkNeg;
	logic        lastViolNeg;
	logic [1:0]  zeroRun;
	logic        bipolarViol;
	logic        hdb3Codeword;
	logic        violEvent;
	logic [14:0] prbsShift;
	logic        prbsErr;
	logic        prbsLocked;
	logic [5:0]  lockRun;
	logic [3:0]  errRun;
	logic        prbsAcquire;
	logic        febeEvent;
	logic        crcEvent;
	logic [15:0] violRun;
	logic [15:0] crcRun;
	logic [15:0] febeRun;
	logic [15:0] fasRun;
	logic [15:0] violLatched;
	logic [15:0] crcLatched;
	logic [15:0] febeLatched;
	logic [15:0] fasLatched;
	logic        readAlarm;
	logic        readEvent;

	// interval timer on receive bit clock, one second or fast interval
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			intervalCount <= 21'h000000;
		end else if (intervalEnd) begin
			intervalCount <= 21'h000000;
		end else if (rxBitStrobe) begin
			intervalCount <= intervalCount + 21'h000001;
		end
	end
	// at or past the end, so a switch to the short interval never overruns
	assign intervalEnd = rxBitStrobe && (fastIntervalSelect ? // see RULE6
		intervalCount >= 21'(FAST_BITS - 1) : intervalCount >= 21'(ONE_SEC_BITS - 1));

	// free-running 2ms boundary used while CRC4 framing is off
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			crcFreeCount <= 13'h0000;
		end else if (crcFreeEnd) begin
			crcFreeCount <= 13'h0000;
		end else if (rxBitStrobe) begin
			crcFreeCount <= crcFreeCount + 13'h0001;
		end
	end
	assign crcFreeEnd = rxBitStrobe && crcFreeCount == 13'(e1s_pkg::CRC_FREE_BITS - 1);

	// transmit clock pin: two-stage sync, then idle timer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			txClkMeta <= 1'b0;
			txClkSync <= 1'b0;
			txClkLast <= 1'b0;
		end else begin
			txClkMeta <= transmitLineClock;
			txClkSync <= txClkMeta;
			txClkLast <= txClkSync;
		end
	end

	// counts cycles without a transition; flags once at the limit
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			txIdleCount <= 19'h00000;
		end else if (txClkSync != txClkLast) begin
			txIdleCount <= 19'h00000;
		end else if (txIdleCount != 19'(TX_LOSS_CYCLES)) begin
			txIdleCount <= txIdleCount + 19'h00001;
		end
	end
	assign txClkLost = txClkSync == txClkLast && txIdleCount == 19'(TX_LOSS_CYCLES - 1); // see RULE8

	// line code tracking: last mark polarity, zero run, last violation polarity
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lastMarkNeg <= 1'b0;
			lastViolNeg <= 1'b0;
			zeroRun     <= 2'h0;
		end else if (rxBitStrobe) begin
			if (rxPositiveRail ^ rxNegativeRail) begin
				lastMarkNeg <= rxNegativeRail;
				zeroRun     <= 2'h0;
			end else if (zeroRun != 2'h3) begin
				zeroRun <= zeroRun + 2'h1;
			end
			if (bipolarViol) begin
				lastViolNeg <= rxNegativeRail;
			end
		end
	end
	// two marks of equal polarity; V of 000V and B00V follows at least two zeros
	assign bipolarViol  = (rxPositiveRail ^ rxNegativeRail) && rxNegativeRail == lastMarkNeg;
	assign hdb3Codeword = rxHdb3Enable && zeroRun >= 2'h2; // see RULE15
	assign violEvent    = rxBitStrobe && bipolarViol && (violationCountSelect ?
		rxNegativeRail == lastViolNeg : !hdb3Codeword); // see RULE14, RULE16

	// 2^15-1 checker: self-synchronising on x^15 + x^14 + 1
	assign prbsErr     = rxDataBit ^ prbsShift[14] ^ prbsShift[13];
	assign prbsAcquire = rxBitStrobe && prbsEnable && !prbsLocked && !prbsErr
		&& prbsShift != 15'h0000 && lockRun == 6'(e1s_pkg::PATTERN_LOCK_BITS - 1);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prbsShift  <= 15'h0000;
			prbsLocked <= 1'b0;
			lockRun    <= 6'h00;
			errRun     <= 4'h0;
		end else if (!prbsEnable) begin
			prbsLocked <= 1'b0;
			lockRun    <= 6'h00;
			errRun     <= 4'h0;
		end else if (rxBitStrobe) begin
			prbsShift <= {prbsShift[13:0], rxDataBit};
			if (!prbsLocked) begin
				lockRun    <= (prbsErr || prbsShift == 15'h0000) ? 6'h00 : lockRun + 6'h01;
				prbsLocked <= prbsAcquire; // see RULE10
				errRun     <= 4'h0;
			end else begin
				errRun     <= prbsErr ? errRun + 4'h1 : 4'h0;
				prbsLocked <= !(prbsErr && errRun == 4'(e1s_pkg::PATTERN_DROP_ERRS - 1));
				lockRun    <= 6'h00;
			end
		end
	end

	// event sources for the counters
	assign febeEvent = prbsEnable ? (rxBitStrobe && prbsLocked && prbsErr) // see RULE13
		: (farEndBlockError && !frameSyncLost && !crcMfSyncLost);
	assign crcEvent  = crcWordError && !frameSyncLost && !crcMfSyncLost; // see RULE20

	// running counters restart at each boundary, saturating in between
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			violRun <= 16'h0000;
			crcRun  <= 16'h0000;
			febeRun <= 16'h0000;
			fasRun  <= 16'h0000;
		end else begin
			violRun <= nextRun(violRun, violEvent, intervalEnd); // see RULE17, RULE12, RULE24
			crcRun  <= nextRun(crcRun, crcEvent, intervalEnd); // see RULE19
			febeRun <= nextRun(febeRun, febeEvent, intervalEnd);
			fasRun  <= nextRun(fasRun, fasWordError && !receiveSyncLoss, intervalEnd);
		end
	end

	// readable copies hold the previous interval's totals
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			violLatched <= 16'h0000;
			crcLatched  <= 16'h0000;
			febeLatched <= 16'h0000;
			fasLatched  <= 16'h0000;
		end else if (intervalEnd) begin
			violLatched <= violRun; // see RULE11, RULE24
			crcLatched  <= crcRun;
			febeLatched <= febeRun;
			fasLatched  <= fasRun;
		end
	end

	// timing event sources, bit positions as in the status register
	always_comb begin
		eventSet = 8'h00;
		eventSet[e1s_pkg::BIT_RX_MF]      = rxSignalingMfStart; // see RULE3
		eventSet[e1s_pkg::BIT_RX_ALIGN]   = rxAlignFrameStart; // see RULE4
		eventSet[e1s_pkg::BIT_TX_MF]      = txMultiframeStart; // see RULE5
		eventSet[e1s_pkg::BIT_TIMER]      = intervalEnd; // see RULE6
		eventSet[e1s_pkg::BIT_TX_ALIGN]   = txAlignFrameStart; // see RULE7
		eventSet[e1s_pkg::BIT_TX_CLKLOSS] = txClkLost; // see RULE8
		eventSet[e1s_pkg::BIT_CRC_MF]     = crc4Enable ? rxCrcMfStart : crcFreeEnd; // see RULE9
		eventSet[e1s_pkg::BIT_PATTERN]    = prbsAcquire; // see RULE10
	end

	assign readAlarm = hostRead && hostAddr == e1s_pkg::ADDR_ALARM_ST;
	assign readEvent = hostRead && hostAddr == e1s_pkg::ADDR_EVENT_ST;

	// sticky status, cleared by reading, a new set wins over the clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			alarmStatus <= e1s_pkg::REG_RESET;
			eventStatus <= e1s_pkg::REG_RESET;
		end else begin
			alarmStatus <= (readAlarm ? 8'h00 : alarmStatus) | rxAlarmLevels; // see RULE22
			eventStatus <= (readEvent ? 8'h00 : eventStatus) | eventSet;
		end
	end

	// mask registers written by the host
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			alarmMask <= e1s_pkg::REG_RESET;
			eventMask <= e1s_pkg::REG_RESET;
		end else if (hostWrite) begin
			if (hostAddr == e1s_pkg::ADDR_ALARM_MSK) begin
				alarmMask <= hostWriteData;
			end
			if (hostAddr == e1s_pkg::ADDR_EVENT_MSK) begin
				eventMask <= hostWriteData;
			end
		end
	end

	// interrupt from any enabled status bit
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			interruptReq <= 1'b0;
		end else begin
			interruptReq <= |(alarmStatus & alarmMask) // see RULE1, RULE23
				| |(eventStatus & eventMask); // see RULE2
		end
	end

	// read data, registered; unmapped addresses read zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hostReadData <= 8'h00;
		end else if (hostRead) begin
			unique case (hostAddr)
				e1s_pkg::ADDR_VIOL_HI:   hostReadData <= violLatched[15:8];
				e1s_pkg::ADDR_VIOL_LO:   hostReadData <= violLatched[7:0];
				e1s_pkg::ADDR_CRC_HI:    hostReadData <= crcLatched[15:8];
				e1s_pkg::ADDR_CRC_LO:    hostReadData <= crcLatched[7:0];
				e1s_pkg::ADDR_FEBE_HI:   hostReadData <= febeLatched[15:8];
				e1s_pkg::ADDR_FEBE_LO:   hostReadData <= febeLatched[7:0];
				e1s_pkg::ADDR_FAS_HI:    hostReadData <= fasLatched[15:8];
				e1s_pkg::ADDR_FAS_LO:    hostReadData <= fasLatched[7:0];
				e1s_pkg::ADDR_ALARM_ST:  hostReadData <= alarmStatus;
				e1s_pkg::ADDR_EVENT_ST:  hostReadData <= eventStatus;
				e1s_pkg::ADDR_ALARM_MSK: hostReadData <= alarmMask;
				e1s_pkg::ADDR_EVENT_MSK: hostReadData <= eventMask;
				default:                 hostReadData <= 8'h00;
			endcase
		end
	end
endmodule : e1s_status_counters
`default_nettype wire

/* verif/e1s_host_model.sv */
// host model: byte reads and writes on the register port
`timescale 1ns/10ps
`default_nettype none
module e1s_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] hostReadData,
	output var  logic [7:0] hostAddr,
	output var  logic       hostWrite,
	output var  logic       hostRead,
	output var  logic [7:0] hostWriteData
);
	// idle bus at time zero
	initial begin
		hostAddr = 8'h5a;
		hostWrite = 1'b0;
		hostRead = 1'b0;
		hostWriteData = 8'ha5;
	end
	// one-cycle write, lines scrambled once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		hostAddr = a;
		hostWriteData = d;
		hostWrite = 1'b1;
		@(negedge clk);
		hostWrite = 1'b0;
		hostAddr = ~a;
		hostWriteData = ~d;
	endtask : wr
	// read, data taken half a cycle after the read edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		hostAddr = a;
		hostRead = 1'b1;
		@(negedge clk);
		hostRead = 1'b0;
		hostAddr = ~a;
		d = hostReadData;
	endtask : rd
endmodule : e1s_host_model
`default_nettype wire

/* verif/e1s_status_assertions.sv */
// checker: interrupt timing and mask readback of the E1 status block
`timescale 1ns/10ps
`default_nettype none
module e1s_status_assertions (
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic [7:0] hostAddr,
	input wire logic       hostWrite,
	input wire logic       hostRead,
	input wire logic [7:0] hostWriteData,
	input wire logic [7:0] hostReadData,
	input wire logic       interruptReq,
	input wire logic [7:0] rxAlarmLevels,
	input wire logic       rxSignalingMfStart,
	input wire logic       rxAlignFrameStart,
	input wire logic       txMultiframeStart,
	input wire logic       txAlignFrameStart,
	input wire logic       rxCrcMfStart,
	input wire logic       crc4Enable
);
	logic [7:0] alMask;
	logic [7:0] evMask;
	logic       ok;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// shadow copies of both mask registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			alMask <= 8'h00;
			evMask <= 8'h00;
		end else if (hostWrite && hostAddr == e1s_pkg::ADDR_ALARM_MSK) begin
			alMask <= hostWriteData;
		end else if (hostWrite && hostAddr == e1s_pkg::ADDR_EVENT_MSK) begin
			evMask <= hostWriteData;
		end
	end
	// no mask update racing the source
	assign ok = !hostWrite;
	AST_ALARM_IRQ: assert property (ok && |(rxAlarmLevels & alMask) |-> ##2 interruptReq)
		else $error("alarm interrupt missing");
	AST_RXMF_IRQ: assert property (ok && rxSignalingMfStart && evMask[7] |-> ##2 interruptReq)
		else $error("rx multiframe interrupt missing");
	AST_RXAF_IRQ: assert property (ok && rxAlignFrameStart && evMask[6] |-> ##2 interruptReq)
		else $error("rx align interrupt missing");
	AST_TXMF_IRQ: assert property (ok && txMultiframeStart && evMask[5] |-> ##2 interruptReq)
		else $error("tx multiframe interrupt missing");
	AST_TXAF_IRQ: assert property (ok && txAlignFrameStart && evMask[3] |-> ##2 interruptReq)
		else $error("tx align interrupt missing");
	AST_CRCMF_IRQ: assert property (ok && crc4Enable && rxCrcMfStart && evMask[1] |-> ##2 interruptReq)
		else $error("crc multiframe interrupt missing");
	AST_IRQ_QUIET: assert property ((ok && alMask == 8'h00 && evMask == 8'h00)[*3] |-> !interruptReq)
		else $error("interrupt with all sources masked");
	AST_EVMASK_RD: assert property (ok && hostRead && hostAddr == 8'h19 |=> hostReadData == $past(evMask))
		else $error("event mask readback wrong");
	AST_ALMASK_RD: assert property (ok && hostRead && hostAddr == 8'h18 |=> hostReadData == $past(alMask))
		else $error("alarm mask readback wrong");
endmodule : e1s_status_assertions
`default_nettype wire

/* verif/tb_top.sv */
// testbench: E1 status block against reference flags and interval counts
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int SEC_BITS = 64;
	localparam int FAST_N   = 16;
	logic       clk, resetn, rxBitStrobe, rxPos, rxNeg, rxData, crc4En, crcErr, fsLost;
	logic       crcLost, transmit_line_clock, tclkRun, prbsEn, fastSel, vSel, hdb3;
	logic [4:0] evPulse;
	logic [7:0] alarms, d;
	logic [14:0] lfsr;
	wire  logic [7:0] hostAddr, hostWriteData, hostReadData;
	wire  logic       hostWrite, hostRead, interruptReq;
	int   seed = 32'hcd59;
	int   failures, checked, cycles, viol, crcCnt, lastPol, lastViol, zeros;
	int   pos[5] = '{7, 6, 5, 3, 1};
	e1s_host_model hostU (.clk(clk), .hostReadData(hostReadData), .hostAddr(hostAddr),
		.hostWrite(hostWrite), .hostRead(hostRead), .hostWriteData(hostWriteData));
	e1s_status_counters #(.ONE_SEC_BITS(SEC_BITS), .FAST_BITS(FAST_N), .TX_LOSS_CYCLES(20)) dut_u (
		.clk(clk), .resetn(resetn), .hostAddr(hostAddr), .hostWrite(hostWrite),
		.hostRead(hostRead), .hostWriteData(hostWriteData), .hostReadData(hostReadData),
		.interruptReq(interruptReq), .rxBitStrobe(rxBitStrobe), .rxPositiveRail(rxPos),
		.rxNegativeRail(rxNeg), .rxDataBit(rxData), .rxAlarmLevels(alarms),
		.rxSignalingMfStart(evPulse[4]), .rxAlignFrameStart(evPulse[3]),
		.txMultiframeStart(evPulse[2]), .txAlignFrameStart(evPulse[1]),
		.rxCrcMfStart(evPulse[0]), .crc4Enable(crc4En), .crcWordError(crcErr),
		.frameSyncLost(fsLost), .crcMfSyncLost(crcLost), .farEndBlockError(crcErr),
		.fasWordError(1'b0), .receiveSyncLoss(1'b0), .transmitLineClock(transmit_line_clock),
		.prbsEnable(prbsEn), .fastIntervalSelect(fastSel), .violationCountSelect(vSel),
		.rxHdb3Enable(hdb3));
	// system clock and unrelated transmit line clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always #20 if (tclkRun) transmit_line_clock = ~transmit_line_clock;
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			stop_test();
		end
	end
	task automatic check(input string w, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask : check
	task automatic rdChk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		hostU.rd(a, d);
		check($sformatf("reg %h", a), {8'h00, e}, {8'h00, d & m});
	endtask : rdChk
	task automatic stop_test();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test
	// one received bit with reference counting
	task automatic sendBit(input int s, input logic err, input logic pd);
		@(negedge clk);
		rxBitStrobe = 1'b1;
		rxPos = (s == 1);
		rxNeg = (s == 2);
		rxData = pd;
		crcErr = err;
		fsLost = ($random(seed) & 7) == 0;
		crcLost = ($random(seed) & 7) == 1;
		if (err && !fsLost && !crcLost) crcCnt++;
		if (s != 0 && s == lastPol) begin
			if (vSel ? s == lastViol : !(hdb3 && zeros >= 2)) viol++;
			lastViol = s;
		end
		if (s != 0) lastPol = s;
		zeros = (s != 0) ? 0 : zeros + 1;
		@(negedge clk);
		rxBitStrobe = 1'b0;
		crcErr = 1'b0;
	endtask : sendBit
	// main sequence
	initial begin
		{resetn, rxBitStrobe, rxPos, rxNeg, rxData, crcErr, fsLost, crcLost} = 8'h00;
		{prbsEn, fastSel, vSel, hdb3, evPulse, alarms} = 17'h0;
		{transmit_line_clock, tclkRun, crc4En} = 3'b011;
		lfsr = 15'h7fff;
		lastPol = 1; // line decoder restarts as if the last mark were positive
		lastViol = 1;
		repeat (3) @(negedge clk);
		resetn = 1'b1;
		rdChk(8'h18, 8'hff, 8'h00);
		rdChk(8'h19, 8'hff, 8'h00);
		d = 8'($random(seed));
		hostU.wr(8'h19, d);
		rdChk(8'h19, 8'hff, d);
		hostU.wr(8'h00, 8'hff);
		rdChk(8'h00, 8'hff, 8'h00);
		rdChk(8'h40, 8'hff, 8'h00);
		for (int k = 0; k < 5; k++) begin
			hostU.wr(8'h19, 8'h01 << pos[k]);
			hostU.rd(8'h0b, d);
			evPulse = 5'h10 >> k;
			@(negedge clk);
			evPulse = 5'h00;
			@(negedge clk);
			check("event irq", 16'h0001, {15'h0, interruptReq});
			rdChk(8'h0b, 8'hea, 8'h01 << pos[k]);
		end
		hostU.wr(8'h19, 8'h00);
		for (int i = 0; i < 8; i++) begin
			hostU.wr(8'h18, 8'h01 << i);
			hostU.rd(8'h0a, d);
			alarms = ~(8'h01 << i);
			repeat (3) @(negedge clk);
			check("masked irq", 16'h0000, {15'h0, interruptReq});
			alarms = 8'h01 << i;
			@(negedge clk);
			alarms = 8'h00;
			@(negedge clk);
			check("alarm irq", 16'h0001, {15'h0, interruptReq});
			rdChk(8'h0a, 8'hff, 8'hff);
		end
		hostU.wr(8'h18, 8'h00);
		tclkRun = 1'b0;
		hostU.rd(8'h0b, d);
		rdChk(8'h0b, 8'h04, 8'h00);
		repeat (30) @(negedge clk);
		rdChk(8'h0b, 8'h04, 8'h04);
		rdChk(8'h0b, 8'h04, 8'h00);
		tclkRun = 1'b1;
		for (int m = 0; m < 3; m++) begin
			vSel = (m == 2);
			hdb3 = (m != 0);
			viol = 0;
			crcCnt = 0;
			for (int i = 1; i < SEC_BITS; i++) sendBit($unsigned($random(seed)) % 3, 1'($random(seed)), 1'b0);
			sendBit(0, 1'b0, 1'b0);
			rdChk(8'h0b, 8'h10, 8'h10);
			rdChk(8'h00, 8'hff, viol[15:8]);
			rdChk(8'h01, 8'hff, viol[7:0]);
			rdChk(8'h02, 8'hff, crcCnt[15:8]);
			rdChk(8'h03, 8'hff, crcCnt[7:0]);
			rdChk(8'h05, 8'hff, crcCnt[7:0]);
		end
		fastSel = 1'b1;
		repeat (FAST_N - 1) sendBit(0, 1'b0, 1'b0);
		rdChk(8'h0b, 8'h11, 8'h00);
		sendBit(0, 1'b0, 1'b0);
		rdChk(8'h0b, 8'h10, 8'h10);
		rdChk(8'h01, 8'hff, 8'h00);
		prbsEn = 1'b1;
		repeat (60) begin
			lfsr = {lfsr[13:0], lfsr[14] ^ lfsr[13]};
			sendBit(0, 1'b0, lfsr[0]);
		end
		rdChk(8'h0b, 8'h01, 8'h01);
		// free-running crc multiframe boundary with crc4 framing off
		prbsEn = 1'b0;
		crc4En = 1'b0;
		rdChk(8'h0b, 8'h02, 8'h00);
		rxBitStrobe = 1'b1;
		repeat (4096) @(negedge clk);
		rxBitStrobe = 1'b0;
		rdChk(8'h0b, 8'h02, 8'h02);
		stop_test();
	end
endmodule : tb_top
bind e1s_status_counters e1s_status_assertions chk_u (.clk(clk), .resetn(resetn),
	.hostAddr(hostAddr), .hostWrite(hostWrite), .hostRead(hostRead),
	.hostWriteData(hostWriteData), .hostReadData(hostReadData), .interruptReq(interruptReq),
	.rxAlarmLevels(rxAlarmLevels), .rxSignalingMfStart(rxSignalingMfStart),
	.rxAlignFrameStart(rxAlignFrameStart), .txMultiframeStart(txMultiframeStart),
	.txAlignFrameStart(txAlignFrameStart), .rxCrcMfStart(rxCrcMfStart), .crc4Enable(crc4Enable));
`default_nettype wire
